// *** core/flash_cmd_consts.svh ***
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// opcodes
`define OP_READ              8'h03
`define OP_FAST_READ         8'h0b
`define OP_IDENT_READ        8'h9f
`define OP_MAKER_PART_READ   8'h90
`define OP_WRITE_LATCH_SET   8'h06
`define OP_WRITE_LATCH_CLEAR 8'h04
`define OP_PAGE_WRITE        8'h02
`define OP_STATUS_FETCH      8'h05
`define OP_STATUS_STORE      8'h01
`define OP_SECTOR_WIPE_A     8'h20
`define OP_SECTOR_WIPE_B     8'hd8
`define OP_ARRAY_ERASE_A     8'hc7
`define OP_ARRAY_ERASE_B     8'h60
`define OP_PARALLEL_ENTER    8'h55
`define OP_PARALLEL_EXIT     8'h45
`define OP_SLEEP_ENTRY       8'hb9
`define OP_SLEEP_RELEASE     8'hab

// frame lengths in serial clocks
`define BITS_OPCODE          12'h008
`define BITS_STATUS_STORE    12'h010
`define BITS_ADDRESSED       12'h020
`define BITS_FAST_DUMMY_END  12'h028
`define BITS_PAGE_MIN        12'h028

// status byte layout
`define STATUS_BUSY_BIT      0
`define STATUS_LATCH_BIT     1
`define STATUS_GUARD_LSB     2

// timing
`define CLK_PERIOD_NS            25
`define SLEEP_ENTRY_DELAY_NS     3000
`define SLEEP_EXIT_DELAY_NS      30000
`define ARRAY_ERASE_DURATION_US  128000
`define SLEEP_ENTRY_CYCLES ((`SLEEP_ENTRY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_EXIT_CYCLES  ((`SLEEP_EXIT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ARRAY_ERASE_CYCLES ((`ARRAY_ERASE_DURATION_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// identity (values arbitrary)
`define MAKER_CODE           8'h5a
`define PART_CODE            16'h2c17

// command queue
`define QUEUE_DEPTH          8

`endif

// *** core/flash_cmd_pkg.sv ***
package flash_cmd_pkg;

    typedef enum logic [4:0] {
        PH_OPCODE = 5'b00001,
        PH_ADDR   = 5'b00010,
        PH_DUMMY  = 5'b00100,
        PH_OUT    = 5'b01000,
        PH_HOLD   = 5'b10000
    } frame_phase_t;

    typedef enum logic [3:0] {
        PW_STANDBY  = 4'b0001,
        PW_ENTERING = 4'b0010,
        PW_SLEEP    = 4'b0100,
        PW_EXITING  = 4'b1000
    } power_state_t;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [23:0] address;
    } cmd_rec_t;

endpackage

// *** core/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int          WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= RESET_VALUE;
            synced <= RESET_VALUE;
        end else begin
            stage1 <= async;
            synced <= stage1;
        end
    end

endmodule

`default_nettype wire

// *** core/cmd_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

module cmd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;

    wire         push = inValid & inReady;
    wire         load = (count != '0) & (~outValid | outReady);
    wire [AW:0]  next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

    assign inReady = (count + {{AW{1'b0}}, outValid}) != (AW+1)'(DEPTH);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr    <= '0;
            rdPtr    <= '0;
            count    <= '0;
            outValid <= 1'b0;
            outData  <= '0;
        end else begin
            wrPtr    <= push ? wrPtr + 1'b1 : wrPtr;
            rdPtr    <= load ? rdPtr + 1'b1 : rdPtr;
            count    <= next_count;
            outValid <= load | (outValid & ~outReady);
            outData  <= load ? mem[rdPtr] : outData;
        end
    end

endmodule

`default_nettype wire

// *** core/serial_flash_cmd.sv ***
// Contract
// - bulk erase needs write latch set first
// - accept C7h always, 60h on 64KB variant
// - bulk erase only if select rises at bit 8
// - busy flag high during erase, low after
// - write latch cleared before erase completes
// - bulk erase ignored unless guard bits zero (non-64KB variant checks guard bits 2:0 only)
// - sleep entry B9h, select rise at bit 8
// - sleep entered after entry delay
// - in sleep ignore all but ABh release
// - sleep entry rejected while operation busy
// - power-on always lands in ordinary standby
// - standby when select high and idle
// - plain release: standby after exit delay
// - signature after three dummies, falling edges
// - signature repeats every eight clocks
// - signature equals part code device byte
// - select high after id reads ends output
// - parallel mode: whole byte per clock
// - 55h enters, 45h leaves parallel mode
// - decode 03h, 0Bh, 9Fh with framing
// - decode 06h,04h,02h,05h,01h with framing
// - sector erase 20h on 64KB, D8h always
// - write enable sets the write latch
`include "flash_cmd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_flash_cmd #(
    parameter int unsigned ERASE_CYCLES = `ARRAY_ERASE_CYCLES
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     csN,
    input  wire logic                     sck,
    input  wire logic                     si,
    input  wire logic                     uniformSectors64,
    input  wire logic [3:0]               blockGuardBits,
    input  wire logic                     externalBusy,
    input  wire logic                     cmdOutReady,
    output logic                          so,
    output logic                          soOe,
    output logic [7:0]                    byteWideOutputPins,
    output logic                          byteWideOe,
    output logic                          writePermitLatch,
    output logic                          operationInProgressFlag,
    output logic                          deepSleepActive,
    output logic                          standbyMode,
    output logic                          parallelMode,
    output logic                          cmdOutValid,
    output flash_cmd_pkg::cmd_rec_t       cmdOut
);

    logic [2:0] pinSync;
    pin_sync #(
        .WIDTH       (3),
        .RESET_VALUE (3'b100)
    ) u_pin_sync (
        .clk    (clk),
        .rst    (rst),
        .async  ({csN, sck, si}),
        .synced (pinSync)
    );

    wire csNS = pinSync[2];
    wire sckS = pinSync[1];
    wire siS  = pinSync[0];

    logic                        csPrev;
    logic                        sckPrev;
    flash_cmd_pkg::frame_phase_t phase;
    flash_cmd_pkg::power_state_t power;
    logic [11:0]                 bitCount;
    logic [7:0]                  shiftIn;
    logic [7:0]                  opcode;
    logic [23:0]                 addr;
    logic                        opAccepted;
    logic [2:0]                  outBit;
    logic [1:0]                  byteIdx;
    logic                        eraseBusy;
    logic [31:0]                 eraseCount;
    logic [15:0]                 powerCount;

    // pin edges seen on the system clock
    wire sckRise = sckS & ~sckPrev & ~csNS;
    wire sckFall = ~sckS & sckPrev & ~csNS;
    wire csRise  = csNS & ~csPrev;

    wire [7:0]  next_shift    = {shiftIn[6:0], siS};
    wire        byteDone      = sckRise & (bitCount[2:0] == 3'h7);
    wire [11:0] next_bitCount = (bitCount == 12'hfff) ? bitCount : bitCount + 12'h001;
    wire        firstByte     = byteDone & (bitCount == `BITS_OPCODE - 12'h001);

    // opcode classification of the byte just completed
    wire isRead      = next_shift == `OP_READ;
    wire isFastRead  = next_shift == `OP_FAST_READ;
    wire isMakerRead = next_shift == `OP_MAKER_PART_READ;
    wire isIdent     = next_shift == `OP_IDENT_READ;
    wire isStatus    = next_shift == `OP_STATUS_FETCH;
    wire isStore     = next_shift == `OP_STATUS_STORE;
    wire isPage      = next_shift == `OP_PAGE_WRITE;
    wire isSector    = (next_shift == `OP_SECTOR_WIPE_B)
                     | (uniformSectors64 & (next_shift == `OP_SECTOR_WIPE_A));
    wire isBulk      = (next_shift == `OP_ARRAY_ERASE_A)
                     | (uniformSectors64 & (next_shift == `OP_ARRAY_ERASE_B));
    wire isRelease   = next_shift == `OP_SLEEP_RELEASE;
    wire isPlain     = (next_shift == `OP_WRITE_LATCH_SET) | (next_shift == `OP_WRITE_LATCH_CLEAR)
                     | (next_shift == `OP_SLEEP_ENTRY) | (next_shift == `OP_PARALLEL_ENTER)
                     | (next_shift == `OP_PARALLEL_EXIT) | isBulk | isStore;
    wire needAddr    = isRead | isFastRead | isMakerRead | isPage | isSector;
    wire known       = needAddr | isIdent | isStatus | isRelease | isPlain;
    wire sleeping    = (power == flash_cmd_pkg::PW_SLEEP) | (power == flash_cmd_pkg::PW_ENTERING);
    wire accepted    = (power == flash_cmd_pkg::PW_STANDBY) ? known : (sleeping & isRelease);

    wire [4:0] phaseAfterOpcode =
        ~accepted ? flash_cmd_pkg::PH_HOLD :
        needAddr  ? flash_cmd_pkg::PH_ADDR :
        isRelease ? flash_cmd_pkg::PH_DUMMY :
        (isIdent | isStatus) ? flash_cmd_pkg::PH_OUT :
        flash_cmd_pkg::PH_HOLD;

    // address and dummy boundaries
    wire addrDone  = byteDone & (phase == flash_cmd_pkg::PH_ADDR)
                   & (bitCount == `BITS_ADDRESSED - 12'h001);
    wire dummyDone = byteDone & (phase == flash_cmd_pkg::PH_DUMMY)
                   & (bitCount == ((opcode == `OP_FAST_READ) ? `BITS_FAST_DUMMY_END : `BITS_ADDRESSED)
                      - 12'h001);
    wire [23:0] pushAddr = (phase == flash_cmd_pkg::PH_ADDR) ? {addr[15:0], next_shift} : addr;

    wire [4:0] phaseAfterAddr =
        (opcode == `OP_FAST_READ) ? flash_cmd_pkg::PH_DUMMY : flash_cmd_pkg::PH_HOLD;

    // chip select rise: commands that execute at the end of the frame; reads push at the address or dummy boundary
    wire busy        = eraseBusy | externalBusy;
    wire guardZero   = uniformSectors64 ? (blockGuardBits == 4'h0)
                                        : (blockGuardBits[2:0] == 3'h0);
    wire exact8      = csRise & opAccepted & (bitCount == `BITS_OPCODE);
    wire opBulk      = (opcode == `OP_ARRAY_ERASE_A)
                     | (uniformSectors64 & (opcode == `OP_ARRAY_ERASE_B));
    wire doWren      = exact8 & (opcode == `OP_WRITE_LATCH_SET);
    wire doWrdi      = exact8 & (opcode == `OP_WRITE_LATCH_CLEAR);
    wire doBulk      = exact8 & opBulk & writePermitLatch & guardZero & ~busy;
    wire doSleep     = exact8 & (opcode == `OP_SLEEP_ENTRY) & ~busy
                     & (power == flash_cmd_pkg::PW_STANDBY);
    wire doParEnter  = exact8 & (opcode == `OP_PARALLEL_ENTER);
    wire doParExit   = exact8 & (opcode == `OP_PARALLEL_EXIT);
    wire doRelease   = csRise & opAccepted & (opcode == `OP_SLEEP_RELEASE) & sleeping;

    wire fifoReady;
    wire writeOk     = csRise & opAccepted & writePermitLatch & ~busy & fifoReady;
    wire doSector    = writeOk & (opcode != `OP_PAGE_WRITE) & (opcode != `OP_STATUS_STORE)
                     & (phase == flash_cmd_pkg::PH_HOLD) & (bitCount == `BITS_ADDRESSED)
                     & ((opcode == `OP_SECTOR_WIPE_B)
                        | (uniformSectors64 & (opcode == `OP_SECTOR_WIPE_A)));
    wire doPage      = writeOk & (opcode == `OP_PAGE_WRITE)
                     & (bitCount >= `BITS_PAGE_MIN) & (bitCount[2:0] == 3'h0);
    wire doStore     = writeOk & (opcode == `OP_STATUS_STORE)
                     & (bitCount == `BITS_STATUS_STORE);
    wire readPush    = (addrDone & (opcode != `OP_FAST_READ) & (opcode != `OP_PAGE_WRITE)
                        & (opcode != `OP_SECTOR_WIPE_A) & (opcode != `OP_SECTOR_WIPE_B))
                     | (dummyDone & (opcode == `OP_FAST_READ));
    wire pushReq     = (readPush & fifoReady) | doSector | doPage | doStore;

    flash_cmd_pkg::cmd_rec_t pushRec;
    assign pushRec.opcode  = opcode;
    assign pushRec.address = pushAddr;

    // output byte selection
    wire [7:0] signature = 8'(`PART_CODE);
    wire [7:0] statusByte = {2'b00, blockGuardBits, writePermitLatch, busy};
    wire [7:0] identByte  = (byteIdx == 2'd0) ? `MAKER_CODE :
                            (byteIdx == 2'd1) ? 8'(`PART_CODE >> 8) :
                            (byteIdx == 2'd2) ? signature : 8'h00;
    wire [7:0] outByte    = (opcode == `OP_SLEEP_RELEASE) ? signature :
                            (opcode == `OP_STATUS_FETCH) ? statusByte : identByte;
    wire       outStep    = sckFall & (phase == flash_cmd_pkg::PH_OUT);
    wire [1:0] next_byteIdx = (byteIdx == 2'd3) ? byteIdx : byteIdx + 2'd1;

    // power state sequencing
    wire powerDone = (power == flash_cmd_pkg::PW_ENTERING)
                   ? (powerCount == 16'(`SLEEP_ENTRY_CYCLES - 1))
                   : (powerCount == 16'(`SLEEP_EXIT_CYCLES - 1));
    flash_cmd_pkg::power_state_t next_power;
    always_comb begin
        next_power = power;
        case (power)
            flash_cmd_pkg::PW_STANDBY: begin
                if (doSleep) begin
                    next_power = flash_cmd_pkg::PW_ENTERING;
                end
            end
            flash_cmd_pkg::PW_ENTERING: begin
                if (doRelease) begin
                    next_power = flash_cmd_pkg::PW_EXITING;
                end else if (powerDone) begin
                    next_power = flash_cmd_pkg::PW_SLEEP;
                end
            end
            flash_cmd_pkg::PW_SLEEP: begin
                if (doRelease) begin
                    next_power = flash_cmd_pkg::PW_EXITING;
                end
            end
            flash_cmd_pkg::PW_EXITING: begin
                if (powerDone) begin
                    next_power = flash_cmd_pkg::PW_STANDBY;
                end
            end
            default: begin
                next_power = flash_cmd_pkg::PW_STANDBY;
            end
        endcase
    end

    wire eraseDone = eraseBusy & (eraseCount == ERASE_CYCLES - 32'd1);

    // pin edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            csPrev  <= 1'b1;
            sckPrev <= 1'b0;
        end else begin
            csPrev  <= csNS;
            sckPrev <= sckS;
        end
    end

    // frame decode
    always_ff @(posedge clk) begin
        if (rst | csNS) begin
            phase      <= flash_cmd_pkg::PH_OPCODE;
            bitCount   <= 12'h000;
            shiftIn    <= 8'h00;
            opAccepted <= 1'b0;
        end else if (sckRise) begin
            bitCount <= next_bitCount;
            shiftIn  <= next_shift;
            if (firstByte) begin
                phase      <= flash_cmd_pkg::frame_phase_t'(phaseAfterOpcode);
                opAccepted <= accepted;
            end else if (addrDone) begin
                phase <= flash_cmd_pkg::frame_phase_t'(phaseAfterAddr);
            end else if (dummyDone) begin
                phase <= (opcode == `OP_SLEEP_RELEASE) ? flash_cmd_pkg::PH_OUT
                                                       : flash_cmd_pkg::PH_HOLD;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            opcode <= 8'h00;
            addr   <= 24'h000000;
        end else if (firstByte) begin
            opcode <= next_shift;
            addr   <= 24'h000000;
        end else if (byteDone & (phase == flash_cmd_pkg::PH_ADDR)) begin
            addr <= {addr[15:0], next_shift};
        end
    end

    // serial and byte-wide output
    always_ff @(posedge clk) begin
        if (rst | csNS) begin
            so                 <= 1'b0;
            soOe               <= 1'b0;
            byteWideOutputPins <= 8'h00;
            byteWideOe         <= 1'b0;
            outBit             <= 3'h0;
            byteIdx            <= 2'd0;
        end else if (outStep & parallelMode) begin
            byteWideOutputPins <= outByte;
            byteWideOe         <= 1'b1;
            byteIdx            <= next_byteIdx;
        end else if (outStep) begin
            so      <= outByte[3'h7 - outBit];
            soOe    <= 1'b1;
            outBit  <= outBit + 3'h1;
            byteIdx <= (outBit == 3'h7) ? next_byteIdx : byteIdx;
        end
    end

    // write latch, parallel mode, erase engine, power
    always_ff @(posedge clk) begin
        if (rst) begin
            writePermitLatch <= 1'b0;
            parallelMode     <= 1'b0;
            eraseBusy        <= 1'b0;
            eraseCount       <= 32'h00000000;
            power            <= flash_cmd_pkg::PW_STANDBY;
            powerCount       <= 16'h0000;
        end else begin
            if (doWren) begin
                writePermitLatch <= 1'b1;
            end else if (doWrdi | doBulk | doSector | doPage | doStore) begin
                writePermitLatch <= 1'b0;
            end
            if (doParEnter) begin
                parallelMode <= 1'b1;
            end else if (doParExit) begin
                parallelMode <= 1'b0;
            end
            if (doBulk) begin
                eraseBusy  <= 1'b1;
                eraseCount <= 32'h00000000;
            end else if (eraseDone) begin
                eraseBusy <= 1'b0;
            end else if (eraseBusy) begin
                eraseCount <= eraseCount + 32'h00000001;
            end
            power      <= next_power;
            powerCount <= (next_power != power) ? 16'h0000 : powerCount + 16'h0001;
        end
    end

    // visible state
    always_ff @(posedge clk) begin
        if (rst) begin
            operationInProgressFlag <= 1'b0;
            deepSleepActive         <= 1'b0;
            standbyMode             <= 1'b1;
        end else begin
            operationInProgressFlag <= busy;
            deepSleepActive         <= power == flash_cmd_pkg::PW_SLEEP;
            standbyMode             <= csNS & ~busy & (power == flash_cmd_pkg::PW_STANDBY);
        end
    end

    cmd_fifo #(
        .WIDTH ($bits(flash_cmd_pkg::cmd_rec_t)),
        .DEPTH (`QUEUE_DEPTH)
    ) u_cmd_fifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (pushReq),
        .inReady  (fifoReady),
        .inData   (pushRec),
        .outValid (cmdOutValid),
        .outReady (cmdOutReady),
        .outData  (cmdOut)
    );

endmodule

`default_nettype wire

// *** verification/serial_flash_cmd_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_chk #(
    parameter int unsigned ERASE_CYCLES = 50
) (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic                    csN,
    input wire logic                    sck,
    input wire logic                    externalBusy,
    input wire logic                    cmdOutReady,
    input wire logic                    so,
    input wire logic                    soOe,
    input wire logic [7:0]              byteWideOutputPins,
    input wire logic                    byteWideOe,
    input wire logic                    writePermitLatch,
    input wire logic                    operationInProgressFlag,
    input wire logic                    deepSleepActive,
    input wire logic                    standbyMode,
    input wire logic                    parallelMode,
    input wire logic                    cmdOutValid,
    input wire flash_cmd_pkg::cmd_rec_t cmdOut
);
    logic        sckQ;
    logic        csQ;
    logic [7:0]  sinceFall;
    logic [11:0] sinceRise;
    logic [31:0] busyRun;
    // cycles since the last pin edges, and length of an erase-only busy run
    always_ff @(posedge clk) begin
        sckQ <= sck;
        csQ <= csN;
        sinceFall <= (sckQ && !sck) ? 8'h00 : sinceFall + {7'h00, sinceFall != 8'hff};
        sinceRise <= (!csQ && csN) ? 12'h000 : sinceRise + {11'h000, sinceRise != 12'hfff};
        busyRun <= (operationInProgressFlag && !externalBusy) ? busyRun + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_sleep_no_standby: assert property (deepSleepActive |-> !standbyMode) else $error("standby in sleep");
    a_erase_drops_latch: assert property ($rose(operationInProgressFlag) && !$past(externalBusy)
        && !$past(externalBusy, 2) |-> !writePermitLatch) else $error("latch kept over erase");
    a_erase_bounded: assert property (busyRun <= ERASE_CYCLES + 4) else $error("erase busy too long");
    a_latch_after_frame: assert property ($rose(writePermitLatch) |-> $past(csN, 2)
        && !$past(deepSleepActive)) else $error("latch set out of frame");
    a_so_after_fall: assert property (soOe && $past(soOe) && $changed(so)
        |-> sinceFall inside {[1:6]}) else $error("serial out moved off fall");
    a_wide_after_fall: assert property (byteWideOe && $past(byteWideOe) && $changed(byteWideOutputPins)
        |-> sinceFall inside {[1:6]}) else $error("wide out moved off fall");
    a_select_ends_out: assert property (csN [*6] |-> !soOe && !byteWideOe) else $error("output after select");
    a_sleep_delay: assert property ($rose(deepSleepActive) |-> sinceRise >= 12'd120) else $error("sleep early");
    a_ext_busy_shown: assert property (externalBusy [*3] |-> operationInProgressFlag) else $error("busy hidden");
    a_queue_holds: assert property (cmdOutValid && !cmdOutReady |=> cmdOutValid && $stable(cmdOut))
        else $error("queue head moved");
    a_wide_needs_par: assert property (byteWideOe |-> parallelMode) else $error("wide pins outside mode");
    c_sleep: cover property ($rose(deepSleepActive));
    c_erase: cover property ($fell(operationInProgressFlag));
    c_wide: cover property (byteWideOe);
    c_stall: cover property (cmdOutValid && !cmdOutReady);
endmodule
bind serial_flash_cmd serial_flash_cmd_chk #(.ERASE_CYCLES(ERASE_CYCLES)) i_chk (.*);
`default_nettype wire

// *** verification/spi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic       clk,
    input  wire logic       so,
    input  wire logic [7:0] pins,
    output var logic        csN,
    output var logic        sck,
    output var logic        si
);
    logic [15:0] got;
    logic [7:0]  gotWide;
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // n bits of d, then rd output clocks; the link clock stands low between frames
    task automatic xfer(input logic [47:0] d, input int n, input int rd);
        @(negedge clk);
        csN = 1'b0;
        for (int i = 0; i < n + rd; i++) begin
            si = (i < n) ? d[n - 1 - i] : ~si;
            repeat (4) @(negedge clk);
            sck = 1'b1;
            repeat (4) @(negedge clk);
            if (i >= n) begin
                got = {got[14:0], so};
                gotWide = pins;
            end
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        csN = 1'b1;
        si = ~si;
        repeat (16) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// *** verification/serial_flash_cmd_test.sv ***
`include "flash_cmd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_test;
    localparam int unsigned ERASE = 50;
    localparam logic [7:0]  SIG = 8'(`PART_CODE);
    // rows: [15] 64KB variant, [14] erase expected, [13] one extra bit, [11:8] guard bits, [7:0] opcode
    localparam logic [15:0] ROWS [5] = '{16'h80c7, 16'h0060, 16'h20c7, 16'h48c7, 16'hc060};
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    uniformSectors64 = 1'b0;
    logic [3:0]              blockGuardBits = 4'h0;
    logic                    externalBusy = 1'b0;
    logic                    cmdOutReady = 1'b0;
    logic                    csN, sck, si, so, soOe, byteWideOe, writePermitLatch, operationInProgressFlag;
    logic                    deepSleepActive, standbyMode, parallelMode, cmdOutValid;
    logic [7:0]              byteWideOutputPins;
    flash_cmd_pkg::cmd_rec_t cmdOut;
    flash_cmd_pkg::cmd_rec_t expQ[$];
    int                      seed = 56247;
    int                      checks = 0;
    int                      failures = 0;
    int                      k;
    logic [23:0]             addr;
    serial_flash_cmd #(.ERASE_CYCLES(ERASE)) i_dut (.*);
    spi_host_model i_host (.clk(clk), .so(so), .pins(byteWideOutputPins), .csN(csN), .sck(sck), .si(si));
    always #12.5 clk = ~clk;
    task automatic results();
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkRec(input flash_cmd_pkg::cmd_rec_t got, input flash_cmd_pkg::cmd_rec_t exp);
        chk(32'(got), 32'(exp));
    endtask
    // sel 0: busy flag, 1: deep sleep, 2: standby
    task automatic waitLevel(input int sel, input logic want, input int lim);
        logic now;
        for (k = 0; k < lim; k++) begin
            now = (sel == 0) ? operationInProgressFlag : ((sel == 1) ? deepSleepActive : standbyMode);
            if (now === want) break;
            @(negedge clk);
        end
        if (k == lim) begin
            failures++;
            results();
        end
    endtask
    always @(posedge clk) begin
        if (cmdOutValid === 1'b1 && cmdOutReady === 1'b1) begin
            chkRec(cmdOut, expQ.pop_front());
        end
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk(32'({standbyMode, deepSleepActive, writePermitLatch, parallelMode}), 32'h8);
        i_host.xfer(48'hc7, 8, 0);
        chk(32'(operationInProgressFlag), 32'h0);
        for (int i = 0; i < 5; i++) begin
            i_host.xfer(48'h06, 8, 0);
            chk(32'(writePermitLatch), 32'h1);
            uniformSectors64 = ROWS[i][15];
            blockGuardBits = (i == 0) ? (4'($random(seed)) | 4'h8) : ROWS[i][11:8];
            i_host.xfer(ROWS[i][13] ? {39'h0, ROWS[i][7:0], 1'b0} : {40'h0, ROWS[i][7:0]}, 8 + int'(ROWS[i][13]), 0);
            chk(32'(operationInProgressFlag), 32'(ROWS[i][14]));
            chk(32'(writePermitLatch), 32'(!ROWS[i][14]));
            if (ROWS[i][14]) waitLevel(0, 1'b0, 2 * ERASE);
        end
        externalBusy = 1'b1;
        i_host.xfer(48'hb9, 8, 0);
        repeat (150) @(negedge clk);
        chk(32'(deepSleepActive), 32'h0);
        externalBusy = 1'b0;
        i_host.xfer(48'hb9, 8, 0);
        waitLevel(1, 1'b1, 200);
        i_host.xfer(48'h06, 8, 0);
        chk(32'(writePermitLatch), 32'h0);
        i_host.xfer({16'h0, 8'hab, 24'($random(seed))}, 32, 16);
        chk(32'(i_host.got), 32'({SIG, SIG}));
        chk(32'({deepSleepActive, standbyMode}), 32'h0);
        waitLevel(2, 1'b1, 1300);
        chk(32'(k > 1150), 32'h1);
        i_host.xfer(48'h55, 8, 0);
        chk(32'(parallelMode), 32'h1);
        i_host.xfer({16'h0, 8'hab, 24'h0}, 32, 2);
        chk(32'(i_host.gotWide), 32'(SIG));
        waitLevel(2, 1'b1, 1300);
        i_host.xfer(48'h45, 8, 0);
        chk(32'(parallelMode), 32'h0);
        i_host.xfer(48'h9f, 8, 24);
        chk(32'(i_host.got), 32'(`PART_CODE));
        // nine reads with the consumer stalled: the ninth finds the queue full and is dropped
        for (int i = 0; i < 9; i++) begin
            addr = 24'($random(seed));
            i_host.xfer((i == 8) ? {8'h00, 8'h0b, addr, 8'h5a} : {16'h0000, 8'h03, addr}, (i == 8) ? 40 : 32, 0);
            if (i < 8) expQ.push_back({8'h03, addr});
        end
        repeat (300) begin
            @(negedge clk);
            cmdOutReady = 1'($random(seed));
        end
        cmdOutReady = 1'b1;
        addr = 24'($random(seed));
        expQ.push_back({8'h0b, addr});
        i_host.xfer({8'h00, 8'h0b, addr, 8'h5a}, 40, 0);
        i_host.xfer(48'h06, 8, 0);
        expQ.push_back({8'hd8, addr});
        i_host.xfer({16'h0, 8'hd8, addr}, 32, 0);
        repeat (8) @(negedge clk);
        chk(32'(expQ.size()), 32'h0);
        results();
    end
endmodule
`default_nettype wire
